// ===== hdl/sid_pkg.sv
// Purpose: Shared constants, types and CRC function of the serial identity slave.
// Assumes: System clock of 10 MHz; one identity slave on the two-wire bus.
// Notes:   Key offsets, the pointer and mode reset values and the timing constants of the slave live here.
package sid_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_NS = 100;                       // System clock period
    localparam int SPIKE_NS = 50;                      // Longest pulse to reject
    localparam int SPIKE_RAW = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPIKE_CYC = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;
    localparam int FAULT_MS = 25;                      // Least bus-fault interval
    localparam int FAULT_CYC = FAULT_MS * (1000000 / CLK_NS);
    localparam int FAULT_W = 18;                       // Width of fault counters
    localparam int SPK_W = 2;                          // Width of filter counters

    // ************************************************************
    // Address space and reset values
    // ************************************************************
    localparam logic [3:0] PTR_FAMILY = 4'h0;          // Family code
    localparam logic [3:0] PTR_SERIAL = 4'h1;          // Serial number, low byte
    localparam logic [3:0] PTR_CRC = 4'h7;             // Identity CRC
    localparam logic [3:0] PTR_CTRL = 4'h8;            // Control byte
    localparam logic [3:0] PTR_RESET = 4'h0;           // Pointer after reset
    localparam logic MODE_RESET = 1'b1;                // Timeout enabled at power-on
    localparam logic [3:0] BIT_LAST = 4'h8;            // Bits in one byte
    localparam logic [7:0] CRC_POLY_REV = 8'h8c;       // x^8+x^5+x^4+1, bit-reversed

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed
    {
        logic scl;
        logic sda;
    } sid_pins_s;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_READ = 3'b101,
        ST_RD_ACK = 3'b110
    } sid_state_e;

    // CRC over the first 56 bits, least significant bit of the family code first
    function automatic logic [7:0] sid_crc8(input logic [55:0] data);
        logic [7:0] crc;
        logic fb;
        crc = 8'h00;
        for (int i = 0; i < 56; i++)
        begin
            fb = crc[0] ^ data[i];
            crc = crc >> 1;
            if (fb)
            begin
                crc = crc ^ CRC_POLY_REV;
            end
        end
        return crc;
    endfunction : sid_crc8

endpackage : sid_pkg

// ===== hdl/sid_bus_slave.sv
// Purpose: Two-wire bus slave that serves a fixed 64-bit identity and a control byte.
// Assumes: SCL and SDA come from the pins unsynchronised; SCL is never stretched.
// Notes:   SDA is open drain: sda_out is always low and sda_oe_out pulls the line.
//
// Function
// - Hold a fixed 64-bit identity: family code, 48-bit serial, CRC byte.
// - In timeout mode, SCL stuck at either level or SDA held low for the fault interval acts as STOP.
// - Reject pulses up to 50 ns on SDA and SCL before decoding.
// - Work as slave at both 100 kHz and 400 kHz.
// - Timeout mode is bit 0 of byte 08h, one after reset, writable.
// - Family code at 00h, serial low byte first at 01h-06h, CRC at 07h.
// - CRC covers the first 56 bits with polynomial x^8+x^5+x^4+1.
// - A timeout releases SDA, leaving the slave ready for a START.
`timescale 1ns/10ps
module sid_bus_slave #(
    parameter logic [6:0] SLAVE_ADDR = 7'h50,          // Arbitrary bus address
    parameter logic [7:0] FAMILY = 8'h5a,              // Arbitrary family code
    parameter logic [47:0] SERIAL = 48'h0123_4567_89ab, // Arbitrary serial number
    parameter int FAULT_CYC = sid_pkg::FAULT_CYC       // Bus-fault interval in cycles
) (
    input wire logic sys_clk_in,                       // 10 MHz system clock
    input wire logic rstn_in,                          // Asynchronous reset, low
    input wire logic clk_en_in,                        // Freezes all state when low
    input wire logic scl_in,                           // SCL pin level
    input wire logic sda_in,                           // SDA pin level
    output logic sda_out,                              // SDA drive value, always low
    output logic sda_oe_out,                           // High while pulling SDA low
    output logic timeout_mode_out                      // Current timeout mode bit
);

    // ************************************************************
    // Identity word
    // ************************************************************
    localparam logic [63:0] ID_WORD = {sid_pkg::sid_crc8({SERIAL, FAMILY}), SERIAL, FAMILY};

    // Byte at a pointer; the control byte reads zero above bit 0
    function automatic logic [7:0] rd_byte(input logic [3:0] ptr, input logic mode);
        logic [7:0] b;
        b = 8'h00;
        if (ptr == sid_pkg::PTR_CTRL)
        begin
            b = {7'h00, mode};
        end
        else if (ptr < sid_pkg::PTR_CTRL)
        begin
            b = ID_WORD[{ptr[2:0], 3'h0} +: 8];
        end
        return b;
    endfunction : rd_byte

    // ************************************************************
    // Input synchronisers and spike filters
    // ************************************************************
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] filt_q;
    logic [1:0] prev_q;
    logic [1:0] raw_w;

    assign raw_w = {scl_in, sda_in};

    // Two flops per pin; only the second stage is read
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
            prev_q <= 2'h3;
        end
        else if (clk_en_in)
        begin
            sync1_q <= raw_w;
            sync2_q <= sync1_q;
            prev_q <= filt_q;
        end
    end

    // A new level is taken only after it persists past the spike width
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_filt
            logic [sid_pkg::SPK_W-1:0] cnt_q;
            always_ff @(posedge sys_clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    cnt_q <= '0;
                    filt_q[gi] <= 1'b1;
                end
                else if (clk_en_in)
                begin
                    if (sync2_q[gi] == filt_q[gi])
                    begin
                        cnt_q <= '0;
                    end
                    else if (cnt_q == sid_pkg::SPK_W'(sid_pkg::SPIKE_CYC))
                    begin
                        cnt_q <= '0;
                        filt_q[gi] <= sync2_q[gi];
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Bus events
    // ************************************************************
    sid_pkg::sid_pins_s cur_w;
    sid_pkg::sid_pins_s old_w;
    logic scl_rise_w;
    logic scl_fall_w;
    logic start_w;
    logic stop_w;

    // Start and stop are SDA edges seen while SCL stays high
    assign cur_w = filt_q;
    assign old_w = prev_q;
    assign scl_rise_w = cur_w.scl & ~old_w.scl;
    assign scl_fall_w = ~cur_w.scl & old_w.scl;
    assign start_w = cur_w.scl & old_w.scl & old_w.sda & ~cur_w.sda;
    assign stop_w = cur_w.scl & old_w.scl & ~old_w.sda & cur_w.sda;

    // ************************************************************
    // Bus-fault timeout
    // ************************************************************
    sid_pkg::sid_state_e state_q;
    sid_pkg::sid_state_e state_d;
    logic [sid_pkg::FAULT_W-1:0] scl_cnt_q;
    logic [sid_pkg::FAULT_W-1:0] sda_cnt_q;
    logic mode_q;
    logic fault_w;
    logic busy_w;
    localparam logic [sid_pkg::FAULT_W-1:0] FAULT_LAST = sid_pkg::FAULT_W'(FAULT_CYC - 1);

    // Counting only while busy keeps an idle high bus from tripping
    assign busy_w = (state_q != sid_pkg::ST_IDLE);
    assign fault_w = mode_q & busy_w & ((scl_cnt_q == FAULT_LAST) | (sda_cnt_q == FAULT_LAST));

    // Stuck-level counters for SCL at either level and SDA low
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            scl_cnt_q <= '0;
            sda_cnt_q <= '0;
        end
        else if (clk_en_in)
        begin
            scl_cnt_q <= (!busy_w || scl_rise_w || scl_fall_w || fault_w) ? '0 : scl_cnt_q + 1'b1;
            sda_cnt_q <= (!busy_w || cur_w.sda || fault_w) ? '0 : sda_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Protocol engine
    // ************************************************************
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] ptr_q;
    logic [3:0] ptr_d;
    logic first_q;
    logic first_d;
    logic rw_q;
    logic rw_d;
    logic oe_q;
    logic oe_d;
    logic mode_d;
    logic [3:0] ptr_next_w;
    logic [7:0] rom_w;

    // Pointer wraps after the control byte
    assign ptr_next_w = (ptr_q == sid_pkg::PTR_CTRL) ? sid_pkg::PTR_FAMILY : ptr_q + 1'b1;
    assign rom_w = rd_byte(ptr_q, mode_q);

    // Next-state decode; SDA changes only after SCL falls, except the release on a bus fault, so hold time is kept
    always_comb
    begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        first_d = first_q;
        rw_d = rw_q;
        oe_d = oe_q;
        mode_d = mode_q;
        if (fault_w || stop_w)
        begin
            state_d = sid_pkg::ST_IDLE;
            oe_d = 1'b0;
        end
        else if (start_w)
        begin
            state_d = sid_pkg::ST_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end
        else
        begin
            case (state_q)
                sid_pkg::ST_ADDR, sid_pkg::ST_WRITE:
                begin
                    if (scl_rise_w)
                    begin
                        shift_d = {shift_q[6:0], cur_w.sda};
                        bit_d = bit_q + 1'b1;
                    end
                    else if (scl_fall_w && bit_q == sid_pkg::BIT_LAST)
                    begin
                        bit_d = 4'h0;
                        oe_d = 1'b1;
                        state_d = sid_pkg::ST_WR_ACK;
                        if (state_q == sid_pkg::ST_ADDR)
                        begin
                            rw_d = shift_q[0];
                            first_d = 1'b1;
                            state_d = sid_pkg::ST_ADDR_ACK;
                            if (shift_q[7:1] != SLAVE_ADDR)
                            begin
                                oe_d = 1'b0;
                                state_d = sid_pkg::ST_IDLE;
                            end
                        end
                        else if (first_q)
                        begin
                            first_d = 1'b0;
                            ptr_d = (shift_q > {4'h0, sid_pkg::PTR_CTRL}) ? sid_pkg::PTR_FAMILY
                                                                          : shift_q[3:0];
                        end
                        else
                        begin
                            if (ptr_q == sid_pkg::PTR_CTRL)
                            begin
                                mode_d = shift_q[0];
                            end
                            ptr_d = ptr_next_w;
                        end
                    end
                end
                sid_pkg::ST_ADDR_ACK, sid_pkg::ST_RD_ACK:
                begin
                    if (state_q == sid_pkg::ST_RD_ACK && scl_rise_w && cur_w.sda)
                    begin
                        state_d = sid_pkg::ST_IDLE;    // Master refused: end of read
                    end
                    else if (scl_fall_w && (rw_q || state_q == sid_pkg::ST_RD_ACK))
                    begin
                        shift_d = rom_w;
                        oe_d = ~rom_w[7];
                        bit_d = 4'h0;
                        ptr_d = ptr_next_w;
                        state_d = sid_pkg::ST_READ;
                    end
                    else if (scl_fall_w)
                    begin
                        oe_d = 1'b0;
                        bit_d = 4'h0;
                        state_d = sid_pkg::ST_WRITE;
                    end
                end
                sid_pkg::ST_WR_ACK:
                begin
                    if (scl_fall_w)
                    begin
                        oe_d = 1'b0;
                        state_d = sid_pkg::ST_WRITE;
                    end
                end
                sid_pkg::ST_READ:
                begin
                    if (scl_rise_w)
                    begin
                        bit_d = bit_q + 1'b1;
                    end
                    else if (scl_fall_w && bit_q == sid_pkg::BIT_LAST)
                    begin
                        oe_d = 1'b0;
                        state_d = sid_pkg::ST_RD_ACK;
                    end
                    else if (scl_fall_w)
                    begin
                        shift_d = {shift_q[6:0], 1'b0};
                        oe_d = ~shift_q[6];
                    end
                end
                sid_pkg::ST_IDLE:
                begin
                    oe_d = 1'b0;
                end
                default:
                begin
                    state_d = sid_pkg::ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q <= sid_pkg::ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= sid_pkg::PTR_RESET;
            first_q <= 1'b0;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            mode_q <= sid_pkg::MODE_RESET;
        end
        else if (clk_en_in)
        begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            first_q <= first_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            mode_q <= mode_d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_q;
    assign timeout_mode_out = mode_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence fault_seq;
        clk_en_in && fault_w ##1 (state_q == sid_pkg::ST_IDLE);
    endsequence

    AST_FAULT_STOP: assert property (clk_en_in && fault_w |-> fault_seq ##0 !sda_oe_out)
        else $error("Bus fault did not return the slave to idle");
    AST_FAULT_GATED: assert property (!mode_q |-> !fault_w)
        else $error("Bus fault raised with timeout mode off");
    AST_MODE_WRITE: assert property ($changed(mode_q) |-> $past(state_q) == sid_pkg::ST_WRITE
                                      && $past(ptr_q) == sid_pkg::PTR_CTRL)
        else $error("Mode bit changed without a control byte write");
    AST_SPIKE: assert property ($changed(filt_q[1]) |-> $past(sync2_q[1], 1) == filt_q[1]
                                 && $past(sync2_q[1], 2) == filt_q[1])
        else $error("SCL level taken without persisting past the spike width");
    AST_IDLE_RELEASE: assert property (state_q == sid_pkg::ST_IDLE |-> !sda_oe_out)
        else $error("SDA driven while idle");
    AST_START_ADDR: assert property (clk_en_in && start_w && !fault_w && !stop_w
                                      |=> state_q == sid_pkg::ST_ADDR && bit_q == 4'h0)
        else $error("START did not restart address decoding");
    AST_ROM_MAP: assert property (rd_byte(sid_pkg::PTR_FAMILY, mode_q) == FAMILY
                                   && rd_byte(sid_pkg::PTR_SERIAL, mode_q) == SERIAL[7:0])
        else $error("Identity byte map wrong");
    AST_CRC: assert property (rd_byte(sid_pkg::PTR_CRC, mode_q) == sid_pkg::sid_crc8({SERIAL, FAMILY}))
        else $error("Identity CRC byte wrong");
    AST_READ_BIT: assert property (state_q == sid_pkg::ST_READ && bit_q < sid_pkg::BIT_LAST
                                    |-> sda_oe_out == ~shift_q[7])
        else $error("Read data bit not on SDA");
    AST_ID_FIXED: assert property (ID_WORD[55:0] == {SERIAL, FAMILY})
        else $error("Identity word not composed of family and serial");

endmodule : sid_bus_slave

// ===== tb/sid_master_model.sv
// Purpose: Behavioural two-wire bus master that drives SCL and pulls SDA.
// Assumes: SDA is resolved outside with a pull-up; nobody stretches SCL.
// Notes:   Timing is in ns and unrelated to the system clock.
`timescale 1ns/10ps
module sid_master_model (
    input wire logic sda_in,   // Resolved SDA level
    output logic scl_out,      // SCL level, sole driver
    output logic sda_oe_out    // High while pulling SDA low
);
    int half_ns = 1250;        // Half period, 400 kHz or slower
    int stall_ns = 0;          // One-off extra low time before the next bit
    bit glitch = 1'b0;         // Adds 50 ns spikes on both lines

    initial
    begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    // SDA moves only a quarter phase after SCL falls, so no false START or STOP
    task automatic bus_start();
        #(half_ns / 4);
        sda_oe_out = 1'b0;
        #(half_ns);
        scl_out = 1'b1;
        #(half_ns);
        sda_oe_out = 1'b1;
        #(half_ns);
        scl_out = 1'b0;
    endtask : bus_start

    task automatic bus_stop();
        #(half_ns / 4);
        sda_oe_out = 1'b1;
        #(half_ns);
        scl_out = 1'b1;
        #(half_ns);
        sda_oe_out = 1'b0;
        #(half_ns);
    endtask : bus_stop

    // Every SCL phase stays far below the fault interval unless a stall is asked for
    task automatic bus_bit(input logic b, output logic s);
        #(half_ns / 4);
        sda_oe_out = ~b;
        #(half_ns + stall_ns);
        stall_ns = 0;
        scl_out = 1'b1;
        #(half_ns / 2);
        s = sda_in;
        if (glitch)
        begin
            sda_oe_out = ~sda_oe_out;
            scl_out = 1'b0;
            #50;
            sda_oe_out = ~sda_oe_out;
            scl_out = 1'b1;
        end
        #(half_ns / 2);
        scl_out = 1'b0;
    endtask : bus_bit

    // Eight bits MSB first, then the ninth bit nb with its sampled level in a
    task automatic bus_byte(input logic [7:0] w, input logic nb, output logic [7:0] r,
                            output logic a);
        for (int i = 7; i >= 0; i--)
            bus_bit(w[i], r[i]);
        bus_bit(nb, a);
    endtask : bus_byte
endmodule : sid_master_model

// ===== tb/serial_id_rom_bus_slave_tb_top.sv
// Purpose: Self-checking bench of the identity bus slave.
// Assumes: Master model is the only SCL driver; SDA has a pull-up.
// Notes:   Fault interval shortened to 3000 cycles to keep the run short; it must still
//          exceed the longest legal SDA-low run at 100 kHz (about 20 bit times).
`timescale 1ns/10ps
module serial_id_rom_bus_slave_tb_top;
    localparam logic [6:0] ADDR = 7'h50;              // Arbitrary bus address
    localparam logic [7:0] FAM = 8'h5a;               // Arbitrary family code
    localparam logic [47:0] SER = 48'h0123_4567_89ab; // Arbitrary serial number
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic scl, m_oe, d_oe, d_sda, mode, ack;
    logic mode_exp = 1'b1;
    logic [7:0] rd, p;
    wire logic sda = ~(m_oe | d_oe); // Wired AND with pull-up
    int num_errors = 0;
    int compares = 0;

    always #50 sys_clk = ~sys_clk;

    sid_bus_slave #(.SLAVE_ADDR(ADDR), .FAMILY(FAM), .SERIAL(SER), .FAULT_CYC(3000)) i_dut (
        .sys_clk_in(sys_clk), .rstn_in(rstn), .clk_en_in(clk_en), .scl_in(scl),
        .sda_in(sda), .sda_out(d_sda), .sda_oe_out(d_oe), .timeout_mode_out(mode));
    sid_master_model i_mst (.sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic finish_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : check

    // Reflected CRC-8, zero start, family code then serial, low bit first
    function automatic logic [7:0] exp_byte(input int idx);
        logic [7:0] crc;
        logic [55:0] d;
        crc = 8'h00;
        d = {SER, FAM};
        for (int i = 0; i < 56; i++)
            crc = (crc >> 1) ^ (((crc[0] ^ d[i]) == 1'b1) ? 8'h8c : 8'h00);
        case (idx)
            0: return FAM;
            7: return crc;
            8: return {7'h00, mode_exp};
            default: return SER[8 * (idx - 1) +: 8];
        endcase
    endfunction : exp_byte

    // Pointer write, repeated START, read address
    task automatic address(input logic [7:0] ptr);
        i_mst.bus_start();
        i_mst.bus_byte({ADDR, 1'b0}, 1'b1, rd, ack);
        check("address ack", 8'h00, {7'h00, ack});
        i_mst.bus_byte(ptr, 1'b1, rd, ack);
        i_mst.bus_start();
        i_mst.bus_byte({ADDR, 1'b1}, 1'b1, rd, ack);
    endtask : address

    task automatic rd_seq(input logic [7:0] ptr, input int n);
        address(ptr);
        for (int i = 0; i < n; i++)
        begin
            i_mst.bus_byte(8'hff, (i == n - 1), rd, ack);
            check("read byte", exp_byte((ptr + i) % 9), rd);
        end
        i_mst.bus_stop();
    endtask : rd_seq

    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] data);
        i_mst.bus_start();
        i_mst.bus_byte({ADDR, 1'b0}, 1'b1, rd, ack);
        i_mst.bus_byte(ptr, 1'b1, rd, ack);
        i_mst.bus_byte(data, 1'b1, rd, ack);
        check("data ack", 8'h00, {7'h00, ack});
        i_mst.bus_stop();
    endtask : wr_reg

    // SCL held low while the slave drives the family MSB, a zero
    task automatic stall_read(input logic oe_after);
        address(8'h00);
        i_mst.stall_ns = 400000;
        fork
            i_mst.bus_byte(8'hff, 1'b1, rd, ack);
            begin
                #10000;
                check("drive before fault", 8'h01, {7'h00, d_oe});
                #340000;
                check("drive after fault", {7'h00, oe_after}, {7'h00, d_oe});
            end
        join
        if (oe_after)
            check("stalled byte", FAM, rd);
        else
            check("ignored after fault", 8'hff, rd);
        i_mst.bus_stop();
    endtask : stall_read

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        void'($urandom(5));
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check("mode after reset", 8'h01, {7'h00, mode});
        check("drive after reset", 8'h00, {7'h00, d_oe});
        check("drive value", 8'h00, {7'h00, d_sda});
        rd_seq(8'h00, 9);
        for (int k = 0; k < 6; k++)
        begin
            i_mst.half_ns = (k == 0) ? 5000 : 1250;
            rd_seq(8'($urandom_range(8)), $urandom_range(10, 1));
        end
        p = 8'($urandom_range(7));
        wr_reg(p, 8'($urandom_range(255)));
        rd_seq(p, 1);
        i_mst.bus_start();
        i_mst.bus_byte({ADDR ^ 7'h01, 1'b0}, 1'b1, rd, ack);
        check("foreign address nack", 8'h01, {7'h00, ack});
        i_mst.bus_stop();
        i_mst.glitch = 1'b1;
        rd_seq(8'h00, 9);
        i_mst.glitch = 1'b0;
        stall_read(1'b0);
        rd_seq(8'h00, 9);
        wr_reg(8'h08, 8'h00);
        mode_exp = 1'b0;
        check("mode cleared", 8'h00, {7'h00, mode});
        rd_seq(8'h08, 1);
        stall_read(1'b1);
        wr_reg(8'h08, 8'hff);
        mode_exp = 1'b1;
        rd_seq(8'h08, 2);
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #8000000;
        num_errors++;
        finish_test();
    end
endmodule : serial_id_rom_bus_slave_tb_top
